/* rtl/asfb_pkg.sv */
package asfb_pkg;
  // signal words: signed, 100 % = 16'h1000, so +-200 % fits with headroom
  localparam int SIG_W = 16;
  localparam logic signed [15:0] FULL_SCALE = 16'sh1000;
  localparam logic signed [15:0] DOUBLE_SCALE = 16'sh2000;

  // register offsets
  localparam logic [7:0] OFS_IDX_SEL = 8'h00;
  localparam logic [7:0] OFS_VAL_ENTRY = 8'h01;
  localparam logic [7:0] OFS_SEL_WORD = 8'h02;
  localparam logic [7:0] OFS_MODE = 8'h03;
  localparam logic [7:0] OFS_C1_UPPER = 8'h04;
  localparam logic [7:0] OFS_C1_LOWER = 8'h05;
  localparam logic [7:0] OFS_C1_MON = 8'h06;
  localparam logic [7:0] OFS_C2_UPPER = 8'h08;
  localparam logic [7:0] OFS_C2_LOWER = 8'h09;
  localparam logic [7:0] OFS_C2_MON = 8'h0a;
  localparam logic [7:0] OFS_LAG_TC = 8'h0c;
  localparam logic [7:0] OFS_LAG_MON = 8'h0d;
  localparam logic [7:0] OFS_MAG_MON = 8'h0e;
  localparam logic [7:0] OFS_ADD_BASE = 8'h10;
  localparam logic [7:0] OFS_ROUTED = 8'h18;
  localparam logic [7:0] OFS_SAVE = 8'h19;
  localparam logic [7:0] OFS_FIX_OUT = 8'h1a;

  // field positions
  localparam int MODE_PIN_BIT = 0;
  localparam int SEL_W = 5;
  localparam int IDX_W = 4;
  localparam int NUM_SETPOINTS = 15;

  // reset values
  localparam logic signed [15:0] RST_UPPER = 16'sh1000;
  localparam logic signed [15:0] RST_LOWER = -16'sh1000;
  localparam logic [12:0] RST_TC = 13'h07d0;
  localparam logic [12:0] TC_MIN = 13'h0001;
  localparam logic [12:0] TC_MAX = 13'h1388;
  localparam int TC_W = 13;

  // timing: one lag step per sample period, which equals one time-constant unit (0.01 s)
  localparam int CLK_HZ = 20_000_000;
  localparam int SAMPLE_MS = 10;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int FRAC_W = 16;
  localparam int DIV_STEPS = 33;

  function automatic logic signed [15:0] asfb_sat(input logic signed [17:0] v, input logic signed [15:0] lim);
    logic signed [17:0] l;
    l = 18'(lim);
    if (v > l) return lim;
    if (v < -l) return -lim;
    return v[15:0];
  endfunction : asfb_sat
endpackage : asfb_pkg

/* rtl/asfb_lag_if.sv */
`timescale 1ns/1ns
interface asfb_lag_if;
  import asfb_pkg::*;
  logic tick;
  logic signed [SIG_W-1:0] x;
  logic [TC_W-1:0] tconst;
  logic signed [SIG_W-1:0] y;
  modport ctl (output tick, output x, output tconst, input y);
  modport lag (input tick, input x, input tconst, output y);
endinterface : asfb_lag_if

/* rtl/asfb_lag.sv */
`timescale 1ns/1ns
module asfb_lag
  import asfb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  asfb_lag_if.lag lif
);
  typedef enum logic [1:0] {LAG_IDLE = 2'b01, LAG_DIV = 2'b10} asfb_lag_e;
  asfb_lag_e state_q;
  // y kept with fraction bits so long time constants still creep forward
  logic signed [31:0] acc_q;
  logic [32:0] num_q;
  logic [13:0] rem_q;
  logic [5:0] cnt_q;
  logic neg_q;
  // divisor latched at the tick so a time-constant write mid-division cannot corrupt the step
  logic [TC_W-1:0] div_q;
  logic signed [16:0] diff;
  logic [16:0] mag;
  logic [13:0] trial;
  logic qbit;
  logic signed [31:0] delta;

  // the part-select drops the sign, so it is restored before widening
  assign diff = 17'(lif.x) - 17'($signed(acc_q[31:FRAC_W]));
  assign mag = diff[16] ? 17'(-diff) : diff;
  assign trial = {rem_q[12:0], num_q[32]};
  assign qbit = trial >= 14'(div_q);
  assign delta = neg_q ? -$signed(num_q[31:0]) : $signed(num_q[31:0]);
  assign lif.y = acc_q[31:FRAC_W];

  // y += (x - y) * Ts / T, gain one; the quotient is formed by shift-subtract
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= LAG_IDLE;
      acc_q <= 32'sh0;
      num_q <= 33'h0;
      rem_q <= 14'h0;
      cnt_q <= 6'h0;
      neg_q <= 1'b0;
      div_q <= RST_TC;
    end else begin
      case (state_q)
        LAG_IDLE: begin
          if (lif.tick) begin
            num_q <= {mag[16:0], 16'h0}; // RQ19
            neg_q <= diff[16];
            div_q <= lif.tconst;
            rem_q <= 14'h0;
            cnt_q <= 6'(DIV_STEPS);
            state_q <= LAG_DIV;
          end
        end
        LAG_DIV: begin
          if (cnt_q == 6'h0) begin
            acc_q <= acc_q + delta; // RQ12 RQ13 RQ19
            state_q <= LAG_IDLE;
          end else begin
            rem_q <= qbit ? trial - 14'(div_q) : trial;
            num_q <= {num_q[31:0], qbit};
            cnt_q <= cnt_q - 6'h1;
          end
        end
        default: state_q <= LAG_IDLE;
      endcase
    end
  end
endmodule : asfb_lag

/* rtl/asfb_top.sv */
// Functional notes
// [RQ1] fifteen stored setpoints, any one selectable onto the setpoint output
// [RQ2] selector zero or above fifteen passes the free analog input through
// [RQ3] software writes the index first, then the value
// [RQ4] stored setpoints are clamped to -100 % .. +100 %
// [RQ5] selector comes from register or synchronised digital pins, always one source
// [RQ6] magnitude output is the absolute value of its input; an input of 16'sh8000 gives 16'sh7fff
// [RQ7] two independent clamps, each with upper, lower and monitor
// [RQ8] input above upper bound outputs the upper bound
// [RQ9] input below lower bound outputs lower bound, else passes input
// [RQ10] software keeps upper above lower; defaults +100 % and -100 %
// [RQ11] input monitors of magnitude, clamp and lag are read only
// [RQ12] lag is first order, unity gain, time constant 0.01 s to 50 s
// [RQ13] lag gain fixed at one so constant input settles to itself
// [RQ14] two adders with three signed inputs each
// [RQ15] each adder adds its first and second inputs
// [RQ16] third input subtracted, result saturated to +-200 %
// [RQ17] unrouted adder input uses its constant; routed input makes it display only
// [RQ18] save command pulses so the constants can go to non-volatile storage
// [RQ19] lag steps once per sample period with saturating fixed point
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module asfb_top
  import asfb_pkg::*;
#(
  parameter int SAMPLE_PERIOD_CYCLES = SAMPLE_CYCLES
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  input wire logic [IDX_W-1:0] SEL_PINS_IN,
  input wire logic signed [15:0] FREE_ANALOG_IN,
  input wire logic signed [15:0] MAG_IN,
  input wire logic signed [15:0] CLAMP1_IN,
  input wire logic signed [15:0] CLAMP2_IN,
  input wire logic signed [15:0] LAG_IN,
  input wire logic [6*16-1:0] ADD_IN,
  input wire logic [5:0] ADD_ROUTED_IN,
  output logic signed [15:0] FIXSP_OUT,
  output logic signed [15:0] MAG_OUT,
  output logic signed [15:0] CLAMP1_OUT,
  output logic signed [15:0] CLAMP2_OUT,
  output logic signed [15:0] LAG_OUT,
  output logic signed [15:0] ADD1_OUT,
  output logic signed [15:0] ADD2_OUT,
  output logic SAVE_OUT
);
  // ---------------- bus decode ----------------
  logic signed [15:0] wdata_s;
  logic wr_idx, wr_val, wr_sel, wr_mode, wr_tc, wr_save;
  logic wr_c1u, wr_c1l, wr_c2u, wr_c2l;
  logic [5:0] wr_add;

  assign wdata_s = $signed(WDATA_IN);
  assign wr_idx = WR_IN && ADDR_IN == OFS_IDX_SEL;
  assign wr_val = WR_IN && ADDR_IN == OFS_VAL_ENTRY;
  assign wr_sel = WR_IN && ADDR_IN == OFS_SEL_WORD;
  assign wr_mode = WR_IN && ADDR_IN == OFS_MODE;
  assign wr_c1u = WR_IN && ADDR_IN == OFS_C1_UPPER;
  assign wr_c1l = WR_IN && ADDR_IN == OFS_C1_LOWER;
  assign wr_c2u = WR_IN && ADDR_IN == OFS_C2_UPPER;
  assign wr_c2l = WR_IN && ADDR_IN == OFS_C2_LOWER;
  assign wr_tc = WR_IN && ADDR_IN == OFS_LAG_TC;
  assign wr_save = WR_IN && ADDR_IN == OFS_SAVE;

  // ---------------- fixed setpoints ----------------
  logic [IDX_W-1:0] idx_q;
  logic [SEL_W-1:0] sel_reg_q;
  logic pin_mode_q;
  logic signed [15:0] sp_q [1:NUM_SETPOINTS];
  logic signed [15:0] sp_entry;
  logic [IDX_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_stable_q;
  logic [SEL_W-1:0] sel_eff;
  logic sel_hit;
  logic signed [15:0] fix_d;
  logic signed [15:0] idx_read;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      idx_q <= 4'h0;
      sel_reg_q <= 5'h00;
      pin_mode_q <= 1'b0;
    end else begin
      if (wr_idx) idx_q <= WDATA_IN[IDX_W-1:0]; // RQ3
      if (wr_sel) sel_reg_q <= WDATA_IN[SEL_W-1:0]; // RQ5
      if (wr_mode) pin_mode_q <= WDATA_IN[MODE_PIN_BIT];
    end
  end

  // pins are asynchronous: a new level counts once the 2nd and 3rd stage agree
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
      pin_stable_q <= 4'h0;
    end else begin
      pin_s1_q <= SEL_PINS_IN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) pin_stable_q <= pin_s3_q; // RQ5
    end
  end

  // value entry is clamped to +-100 %; an index of zero stores nothing
  assign sp_entry = asfb_sat(18'(wdata_s), FULL_SCALE); // RQ4

  generate
    for (genvar i = 1; i <= NUM_SETPOINTS; i++) begin : g_sp
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          sp_q[i] <= 16'sh0;
        end else if (wr_val && idx_q == IDX_W'(i)) begin
          sp_q[i] <= sp_entry; // RQ1 RQ3
        end
      end
    end
  endgenerate

  assign sel_eff = pin_mode_q ? {1'b0, pin_stable_q} : sel_reg_q; // RQ5
  assign sel_hit = sel_eff != 5'h00 && sel_eff <= 5'(NUM_SETPOINTS);
  assign fix_d = sel_hit ? sp_q[sel_eff[IDX_W-1:0]] : FREE_ANALOG_IN; // RQ1 RQ2
  assign idx_read = idx_q == 4'h0 ? 16'sh0 : sp_q[idx_q];

  // ---------------- magnitude ----------------
  logic signed [15:0] mag_d;
  // the most negative word has no positive twin, so it saturates
  assign mag_d = MAG_IN == 16'sh8000 ? 16'sh7fff : (MAG_IN[15] ? -MAG_IN : MAG_IN); // RQ6

  // ---------------- clamps ----------------
  logic signed [15:0] c1_up_q, c1_lo_q, c2_up_q, c2_lo_q;
  logic signed [15:0] bound_entry;
  logic signed [15:0] c1_d, c2_d;

  assign bound_entry = asfb_sat(18'(wdata_s), DOUBLE_SCALE);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      c1_up_q <= RST_UPPER; // RQ10
      c1_lo_q <= RST_LOWER;
      c2_up_q <= RST_UPPER;
      c2_lo_q <= RST_LOWER;
    end else begin
      if (wr_c1u) c1_up_q <= bound_entry; // RQ7
      if (wr_c1l) c1_lo_q <= bound_entry;
      if (wr_c2u) c2_up_q <= bound_entry;
      if (wr_c2l) c2_lo_q <= bound_entry;
    end
  end

  // upper is tested first; with bounds swapped by software, inputs above the upper get the upper, all others the lower
  assign c1_d = CLAMP1_IN > c1_up_q ? c1_up_q : (CLAMP1_IN < c1_lo_q ? c1_lo_q : CLAMP1_IN); // RQ8 RQ9
  assign c2_d = CLAMP2_IN > c2_up_q ? c2_up_q : (CLAMP2_IN < c2_lo_q ? c2_lo_q : CLAMP2_IN); // RQ8 RQ9

  // ---------------- lag ----------------
  logic [TC_W-1:0] tc_q;
  logic [TC_W-1:0] tc_entry;
  logic [31:0] div_cnt_q;
  logic tick_q;
  asfb_lag_if lag_bus ();

  assign tc_entry = WDATA_IN < 16'(TC_MIN) ? TC_MIN : (WDATA_IN > 16'(TC_MAX) ? TC_MAX : WDATA_IN[TC_W-1:0]);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tc_q <= RST_TC;
      div_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      if (wr_tc) tc_q <= tc_entry; // RQ12
      tick_q <= div_cnt_q == 32'(SAMPLE_PERIOD_CYCLES - 1); // RQ19
      div_cnt_q <= div_cnt_q == 32'(SAMPLE_PERIOD_CYCLES - 1) ? 32'h0 : div_cnt_q + 32'h1;
    end
  end

  assign lag_bus.tick = tick_q;
  // input limited to +-200 % so the difference never wraps
  assign lag_bus.x = asfb_sat(18'(LAG_IN), DOUBLE_SCALE); // RQ19
  assign lag_bus.tconst = tc_q;

  asfb_lag u_lag (
    .clk(CLK_IN),
    .rst(RST_IN),
    .lif(lag_bus.lag)
  );

  // ---------------- adders ----------------
  logic signed [15:0] add_const_q [0:5];
  logic signed [15:0] add_eff [0:5];
  logic signed [17:0] sum1, sum2;
  logic signed [15:0] add1_d, add2_d;
  logic [2:0] add_rd_idx;

  generate
    for (genvar k = 0; k < 6; k++) begin : g_add
      assign wr_add[k] = WR_IN && ADDR_IN == OFS_ADD_BASE + 8'(k + (k / 3));
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          add_const_q[k] <= 16'sh0;
        end else if (wr_add[k] && !ADD_ROUTED_IN[k]) begin
          add_const_q[k] <= bound_entry; // RQ17
        end
      end
      assign add_eff[k] = ADD_ROUTED_IN[k] ? $signed(ADD_IN[k*16 +: 16]) : add_const_q[k]; // RQ17
    end
  endgenerate

  assign sum1 = 18'(add_eff[0]) + 18'(add_eff[1]) - 18'(add_eff[2]); // RQ14 RQ15 RQ16
  assign sum2 = 18'(add_eff[3]) + 18'(add_eff[4]) - 18'(add_eff[5]); // RQ14 RQ15 RQ16
  assign add1_d = asfb_sat(sum1, DOUBLE_SCALE); // RQ16
  assign add2_d = asfb_sat(sum2, DOUBLE_SCALE); // RQ16

  // ---------------- outputs ----------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FIXSP_OUT <= 16'sh0;
      MAG_OUT <= 16'sh0;
      CLAMP1_OUT <= 16'sh0;
      CLAMP2_OUT <= 16'sh0;
      LAG_OUT <= 16'sh0;
      ADD1_OUT <= 16'sh0;
      ADD2_OUT <= 16'sh0;
      SAVE_OUT <= 1'b0;
    end else begin
      FIXSP_OUT <= fix_d;
      MAG_OUT <= mag_d;
      CLAMP1_OUT <= c1_d;
      CLAMP2_OUT <= c2_d;
      LAG_OUT <= lag_bus.y;
      ADD1_OUT <= add1_d;
      ADD2_OUT <= add2_d;
      SAVE_OUT <= wr_save; // RQ18
    end
  end

  // ---------------- read back ----------------
  // monitors have no write decode at all, so writes to them are dropped
  logic [15:0] rd_mux;
  logic rd_add;

  assign rd_add = ADDR_IN >= OFS_ADD_BASE && ADDR_IN < OFS_ROUTED && ADDR_IN[1:0] != 2'b11;
  assign add_rd_idx = 3'(ADDR_IN[2] ? 3 + ADDR_IN[1:0] : ADDR_IN[1:0]);
  assign rd_mux =
    ADDR_IN == OFS_IDX_SEL ? 16'(idx_q) :
    ADDR_IN == OFS_VAL_ENTRY ? idx_read :
    ADDR_IN == OFS_SEL_WORD ? 16'(sel_eff) :
    ADDR_IN == OFS_MODE ? 16'(pin_mode_q) :
    ADDR_IN == OFS_C1_UPPER ? c1_up_q :
    ADDR_IN == OFS_C1_LOWER ? c1_lo_q :
    ADDR_IN == OFS_C1_MON ? CLAMP1_IN : // RQ11
    ADDR_IN == OFS_C2_UPPER ? c2_up_q :
    ADDR_IN == OFS_C2_LOWER ? c2_lo_q :
    ADDR_IN == OFS_C2_MON ? CLAMP2_IN : // RQ11
    ADDR_IN == OFS_LAG_TC ? 16'(tc_q) :
    ADDR_IN == OFS_LAG_MON ? LAG_IN : // RQ11
    ADDR_IN == OFS_MAG_MON ? MAG_IN : // RQ11
    rd_add ? add_eff[add_rd_idx] : // RQ17
    ADDR_IN == OFS_ROUTED ? 16'(ADD_ROUTED_IN) :
    ADDR_IN == OFS_FIX_OUT ? FIXSP_OUT :
    16'h0000;

  // data stands only in the cycle after the read strobe
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 16'h0000;
    end else begin
      RDATA_OUT <= RD_IN ? rd_mux : 16'h0000;
    end
  end
endmodule : asfb_top

/* tb/asfb_chk_monitor.sv */
`timescale 1ns/1ns
module asfb_chk
  import asfb_pkg::*;
#(
  parameter int SAMPLE_PERIOD_CYCLES = SAMPLE_CYCLES
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic [IDX_W-1:0] SEL_PINS_IN,
  input wire logic signed [15:0] FREE_ANALOG_IN,
  input wire logic signed [15:0] MAG_IN,
  input wire logic signed [15:0] CLAMP1_IN,
  input wire logic signed [15:0] CLAMP2_IN,
  input wire logic signed [15:0] LAG_IN,
  input wire logic [6*16-1:0] ADD_IN,
  input wire logic [5:0] ADD_ROUTED_IN,
  input wire logic signed [15:0] FIXSP_OUT,
  input wire logic signed [15:0] MAG_OUT,
  input wire logic signed [15:0] CLAMP1_OUT,
  input wire logic signed [15:0] CLAMP2_OUT,
  input wire logic signed [15:0] LAG_OUT,
  input wire logic signed [15:0] ADD1_OUT,
  input wire logic signed [15:0] ADD2_OUT,
  input wire logic SAVE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [4:0] sel_q;
  logic mode_q;
  logic signed [15:0] up_q;
  logic signed [15:0] lo_q;
  logic signed [17:0] s1;
  logic signed [17:0] s2;
  logic signed [15:0] e1;
  logic signed [15:0] e2;
  // shadows assume in-range bound writes, so write saturation is not modelled
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_q <= 5'h00;
      mode_q <= 1'b0;
      up_q <= RST_UPPER;
      lo_q <= RST_LOWER;
    end else begin
      if (WR_IN && ADDR_IN == OFS_SEL_WORD) sel_q <= WDATA_IN[4:0];
      if (WR_IN && ADDR_IN == OFS_MODE) mode_q <= WDATA_IN[0];
      if (WR_IN && ADDR_IN == OFS_C1_UPPER) up_q <= WDATA_IN;
      if (WR_IN && ADDR_IN == OFS_C1_LOWER) lo_q <= WDATA_IN;
    end
  end
  assign s1 = 18'($signed(ADD_IN[15:0])) + 18'($signed(ADD_IN[31:16])) - 18'($signed(ADD_IN[47:32]));
  assign s2 = 18'($signed(ADD_IN[63:48])) + 18'($signed(ADD_IN[79:64])) - 18'($signed(ADD_IN[95:80]));
  assign e1 = s1 > 18'sh2000 ? DOUBLE_SCALE : (s1 < -18'sh2000 ? -DOUBLE_SCALE : s1[15:0]);
  assign e2 = s2 > 18'sh2000 ? DOUBLE_SCALE : (s2 < -18'sh2000 ? -DOUBLE_SCALE : s2[15:0]);
  clamp_upper_a: assert property (CLAMP1_IN > up_q |=> CLAMP1_OUT == $past(up_q))
    else $error("clamp1 output not at upper bound");
  clamp_lower_a: assert property (CLAMP1_IN < lo_q && CLAMP1_IN <= up_q |=> CLAMP1_OUT == $past(lo_q))
    else $error("clamp1 output not at lower bound");
  clamp_pass_a: assert property (CLAMP1_IN >= lo_q && CLAMP1_IN <= up_q |=> CLAMP1_OUT == $past(CLAMP1_IN))
    else $error("clamp1 did not pass its input");
  clamp_two_a: assert property (CLAMP2_IN > FULL_SCALE |=> CLAMP2_OUT == FULL_SCALE)
    else $error("clamp2 not at its own upper bound");
  mag_neg_a: assert property (MAG_IN[15] |=> MAG_OUT == ($past(MAG_IN) == 16'sh8000 ? 16'sh7fff : -$past(MAG_IN)))
    else $error("magnitude of negative input wrong");
  adder_one_a: assert property (&ADD_ROUTED_IN[2:0] |=> ADD1_OUT == $past(e1))
    else $error("adder1 sum wrong");
  adder_two_a: assert property (&ADD_ROUTED_IN[5:3] |=> ADD2_OUT == $past(e2))
    else $error("adder2 sum wrong");
  save_pulse_a: assert property (1'b1 |=> SAVE_OUT == $past(WR_IN && ADDR_IN == OFS_SAVE))
    else $error("save pulse wrong");
  free_input_a: assert property (!mode_q && (sel_q == 5'h00 || sel_q > 5'h0f) |=> FIXSP_OUT == $past(FREE_ANALOG_IN))
    else $error("free analog input not passed");
endmodule : asfb_chk

bind asfb_top asfb_chk #(.SAMPLE_PERIOD_CYCLES(SAMPLE_PERIOD_CYCLES)) u_chk (.*);

/* tb/asfb_src_model.sv */
`timescale 1ns/1ns
module asfb_src_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ld_in,
  input wire logic [3:0] tgt_in,
  input wire logic [15:0] val_in,
  output logic [16*11-1:0] sig_out,
  output logic [5:0] routed_out
);
  logic [15:0] tab_q [11];
  // one target per cycle, like a routing table updated by software
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tab_q <= '{default: 16'h0000};
      routed_out <= 6'h00;
    end else if (ld_in && tgt_in == 4'hb) begin
      routed_out <= val_in[5:0];
    end else if (ld_in) begin
      tab_q[tgt_in] <= val_in;
    end
  end
  for (genvar i = 0; i < 11; i++) begin : g_sig
    assign sig_out[16*i +: 16] = tab_q[i];
  end
endmodule : asfb_src_model

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  import asfb_pkg::*;
  localparam int SP = 64;
  typedef struct {int s; int due; logic [15:0] v;} asfb_note_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] pins = 4'h0;
  logic ld = 1'b0;
  logic [3:0] tgt = 4'h0;
  logic [15:0] val = 16'h0000;
  logic [175:0] sig;
  logic [5:0] routed;
  logic [15:0] o [8];
  logic save;
  logic signed [15:0] sp [16];
  asfb_note_s q[$];
  int cyc = 0;
  int n_mismatch = 0;
  int n_compared = 0;
  asfb_src_model u_src (.clk_in(clk), .rst_in(rst), .ld_in(ld), .tgt_in(tgt), .val_in(val), .sig_out(sig),
    .routed_out(routed));
  asfb_top #(.SAMPLE_PERIOD_CYCLES(SP)) uut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(o[0]), .SEL_PINS_IN(pins), .FREE_ANALOG_IN(sig[15:0]),
    .MAG_IN(sig[31:16]), .CLAMP1_IN(sig[47:32]), .CLAMP2_IN(sig[63:48]), .LAG_IN(sig[79:64]),
    .ADD_IN(sig[175:80]), .ADD_ROUTED_IN(routed), .FIXSP_OUT(o[1]), .MAG_OUT(o[2]), .CLAMP1_OUT(o[3]),
    .CLAMP2_OUT(o[4]), .LAG_OUT(o[5]), .ADD1_OUT(o[6]), .ADD2_OUT(o[7]), .SAVE_OUT(save));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic stop_test();
    if (q.size() != 0) n_mismatch++;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // notes fall due in push order, so only the head needs looking at
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end else begin
      while (q.size() > 0 && q[0].due == cyc) begin
        check(q[0].s == 8 ? {15'h0000, save} : o[q[0].s], q[0].v);
        void'(q.pop_front());
      end
    end
  end
  task automatic push(int s, logic [15:0] v);
    q.push_back('{s, cyc + 2, v});
  endtask : push
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [7:0] a, logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    push(0, v);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic src(int t, logic [15:0] d);
    @(posedge clk);
    ld <= 1'b1;
    tgt <= 4'(t);
    val <= d;
    @(posedge clk);
    ld <= 1'b0;
  endtask : src
  function automatic logic [15:0] sat3(logic signed [15:0] a, logic signed [15:0] b, logic signed [15:0] c);
    int s;
    s = a + b - c;
    return s > 8192 ? 16'h2000 : (s < -8192 ? 16'he000 : 16'(s));
  endfunction : sat3
  initial begin
    logic signed [15:0] x;
    logic signed [15:0] a [6];
    void'($urandom(32'h3c6f3e59));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_C1_UPPER, FULL_SCALE);
    rd_reg(OFS_C1_LOWER, -FULL_SCALE);
    rd_reg(OFS_LAG_TC, 16'h07d0);
    rd_reg(8'h1f, 16'h0000);
    $display("reset test done");
    for (int k = 1; k < 16; k++) begin
      x = 16'($urandom());
      sp[k] = x > FULL_SCALE ? FULL_SCALE : (x < -FULL_SCALE ? -FULL_SCALE : x);
      wr_reg(OFS_IDX_SEL, 16'(k));
      wr_reg(OFS_VAL_ENTRY, x);
    end
    for (int k = 0; k < 32; k++) begin
      src(0, 16'(k * 291));
      wr_reg(OFS_SEL_WORD, 16'(k));
      push(1, (k > 0 && k < 16) ? sp[k] : 16'(k * 291));
    end
    wr_reg(OFS_MODE, 16'h0001);
    pins <= 4'h7;
    repeat (6) @(posedge clk);
    push(1, sp[7]);
    rd_reg(OFS_SEL_WORD, 16'h0007);
    wr_reg(OFS_MODE, 16'h0000);
    $display("setpoint test done");
    for (int k = 0; k < 20; k++) begin
      x = k == 0 ? 16'sh8000 : 16'($urandom());
      src(1, x);
      push(2, x == 16'sh8000 ? 16'h7fff : (x < 0 ? -x : x));
    end
    wr_reg(OFS_MAG_MON, 16'h0000);
    rd_reg(OFS_MAG_MON, x);
    wr_reg(OFS_C1_UPPER, 16'h0800);
    wr_reg(OFS_C1_LOWER, 16'hfc00);
    for (int k = 0; k < 12; k++) begin
      x = k == 0 ? 16'sh0800 : (k == 1 ? -16'sh0400 : 16'($urandom_range(0, 6144)) - 16'sh0c00);
      src(2, x);
      push(3, x > 16'sh0800 ? 16'h0800 : (x < -16'sh0400 ? 16'hfc00 : x));
      src(3, x + x);
      push(4, x + x > FULL_SCALE ? FULL_SCALE : (x + x < -FULL_SCALE ? -FULL_SCALE : x + x));
    end
    rd_reg(OFS_C1_MON, x);
    $display("magnitude and clamp test done");
    src(11, 16'h003f);
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 6; j++) begin
        a[j] = k < 2 ? ((j % 3 == 2) ^ (k == 1) ? 16'sh9000 : 16'sh7000) : 16'($urandom());
        src(5 + j, a[j]);
      end
      push(6, sat3(a[0], a[1], a[2]));
      push(7, sat3(a[3], a[4], a[5]));
    end
    src(11, 16'h0000);
    for (int j = 0; j < 6; j++) begin
      a[j] = 16'($urandom_range(0, 16384)) - 16'sh2000;
      wr_reg(OFS_ADD_BASE + 8'(j + j / 3), a[j]);
    end
    push(6, sat3(a[0], a[1], a[2]));
    push(7, sat3(a[3], a[4], a[5]));
    rd_reg(OFS_ADD_BASE, a[0]);
    @(posedge clk);
    wr <= 1'b1;
    addr <= OFS_SAVE;
    push(8, 16'h0001);
    @(posedge clk);
    wr <= 1'b0;
    push(8, 16'h0000);
    $display("adder and save test done");
    wr_reg(OFS_LAG_TC, 16'h0000);
    rd_reg(OFS_LAG_TC, 16'h0001);
    wr_reg(OFS_LAG_TC, 16'h1fff);
    rd_reg(OFS_LAG_TC, 16'h1388);
    wr_reg(OFS_LAG_TC, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      x = k == 0 ? 16'sh0a00 : -16'sh0600;
      src(4, x);
      // one sample period plus the division latency
      repeat (SP + 40) @(posedge clk);
      push(5, x);
      rd_reg(OFS_LAG_MON, x);
    end
    wr_reg(OFS_LAG_TC, 16'h0002);
    src(4, 16'h0000);
    // halving steps from a negative level must creep back to exactly zero
    repeat (SP * 20) @(posedge clk);
    push(5, 16'h0000);
    $display("lag test done");
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule : tb
